// file: logic/host_bridge_cmd_status.sv
`timescale 1ns/1ps
module host_bridge_cmd_status
   import host_bridge_cfg_pkg::*;
#(
   parameter int ERR_COND_W = 8
) (
   input wire logic core_clk_i,                 // core clock, 20 MHz
   input wire logic rst_i,                      // sync reset, high
   input wire cfg_req_t cfg_req_i,              // config cycle request
   output logic cfg_ack_o,                      // access done
   output logic [31:0] cfg_rdata_o,             // read data
   input wire logic [ERR_COND_W-1:0] err_cond_i, // error events
   input wire logic [ERR_COND_W-1:0] err_cmd_en_i, // per-condition enables
   input wire logic other_func_serr_en_i,       // other functions' enables
   input wire hub_evt_t hub_evt_i,              // abort completions and abort cycles seen
   output logic serr_msg_o,                     // send one message
   output logic serr_mech_en_o,                 // message path enabled
   output logic bus_master_en_o,                // always 1
   output logic mem_space_en_o,                 // always 1
   output logic write_invalidate_o              // always 0
);

   if (ERR_COND_W < 1 || ERR_COND_W > 32) begin : g_chk
      $error("ERR_COND_W must be 1 to 32");
   end

   function automatic logic dw_hit(input logic [7:0] addr);
      dw_hit = (addr[7:DW_LSB] == CMD_OFFSET[7:DW_LSB]);
   endfunction : dw_hit

   // write touches the byte lane holding this dword bit
   function automatic logic lane_wr(input cfg_req_t r, input int bitpos);
      lane_wr = r.wr && dw_hit(r.addr) && r.be[bitpos / 8];
   endfunction : lane_wr

   logic system_error_msg_enable_r;
   logic serr_msg_r;
   logic serr_mech_en_r;
   logic cfg_ack_r;
   logic [31:0] cfg_rdata_r;
   logic [31:0] cfg_rdata_nxt;
   logic rd_hit_r;
   logic err_hit;
   logic signalled_system_error;
   logic received_master_abort;
   logic received_target_abort;
   logic sys_err_clr;
   logic [15:0] cmd_val;
   logic [15:0] sts_val;

   // only the enable is stored; hardwired bits come from constants
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         system_error_msg_enable_r <= CMD_RESET[CMD_SERR_EN_BIT];
      end else if (lane_wr(cfg_req_i, CMD_SERR_EN_BIT)) begin
         system_error_msg_enable_r <=
            cfg_req_i.wdata[CMD_SERR_EN_BIT];
      end
   end

   assign err_hit = |(err_cond_i & err_cmd_en_i);

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         serr_msg_r <= 1'b0;
      end else begin
         serr_msg_r <= system_error_msg_enable_r & err_hit;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         serr_mech_en_r <= 1'b0;
      end else begin
         serr_mech_en_r <= system_error_msg_enable_r | other_func_serr_en_i;
      end
   end

   assign sys_err_clr = lane_wr(cfg_req_i, STS_SHIFT + STS_SYS_ERR_BIT) &&
      cfg_req_i.wdata[STS_SHIFT + STS_SYS_ERR_BIT];

   sticky_flag u_sys_err (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .set_i(serr_msg_r),
      .clr_i(sys_err_clr),
      .q_o(signalled_system_error)
   );

   // abort flags have no clear path: read-only to software
   sticky_flag u_master_abort (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .set_i(hub_evt_i.ma_cpl | hub_evt_i.ma_cycle),
      .clr_i(1'b0),
      .q_o(received_master_abort)
   );

   sticky_flag u_target_abort (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .set_i(hub_evt_i.ta_cpl | hub_evt_i.ta_cycle),
      .clr_i(1'b0),
      .q_o(received_target_abort)
   );

   always_comb begin
      cmd_val = CMD_ONES;
      cmd_val[CMD_SERR_EN_BIT] = system_error_msg_enable_r;
   end

   always_comb begin
      sts_val = STS_ONES;
      sts_val[STS_SYS_ERR_BIT] = signalled_system_error;
      sts_val[STS_MASTER_ABORT_BIT] = received_master_abort;
      sts_val[STS_TARGET_ABORT_BIT] = received_target_abort;
   end

   always_comb begin
      cfg_rdata_nxt = '0;
      if (cfg_req_i.rd && dw_hit(cfg_req_i.addr)) begin
         cfg_rdata_nxt = {sts_val, cmd_val};
      end
   end

   // other offsets belong to neighbouring registers and read as zero here
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         cfg_rdata_r <= '0;
         rd_hit_r <= 1'b0;
      end else begin
         cfg_rdata_r <= cfg_rdata_nxt;
         rd_hit_r <= cfg_req_i.rd && dw_hit(cfg_req_i.addr);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         cfg_ack_r <= 1'b0;
      end else begin
         cfg_ack_r <= cfg_req_i.rd | cfg_req_i.wr;
      end
   end

   assign cfg_ack_o = cfg_ack_r;
   assign cfg_rdata_o = cfg_rdata_r;
   assign serr_msg_o = serr_msg_r;
   assign serr_mech_en_o = serr_mech_en_r;
   assign bus_master_en_o = 1'b1;
   assign mem_space_en_o = 1'b1;
   assign write_invalidate_o = 1'b0;

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   sequence seq_cfg_read;
      cfg_req_i.rd && dw_hit(cfg_req_i.addr);
   endsequence

   sequence seq_cfg_any;
      cfg_req_i.rd || cfg_req_i.wr;
   endsequence

   sequence seq_sys_err_w1c;
      lane_wr(cfg_req_i, STS_SHIFT + STS_SYS_ERR_BIT) &&
         cfg_req_i.wdata[STS_SHIFT + STS_SYS_ERR_BIT];
   endsequence

   sequence seq_sys_err_w0;
      lane_wr(cfg_req_i, STS_SHIFT + STS_SYS_ERR_BIT) &&
         !cfg_req_i.wdata[STS_SHIFT + STS_SYS_ERR_BIT];
   endsequence

   chk_ack_follows: assert property (
      seq_cfg_any |=> cfg_ack_o)
      else $error("access not acknowledged");

   chk_ack_idle: assert property (
      !cfg_req_i.rd && !cfg_req_i.wr |=> !cfg_ack_o)
      else $error("acknowledge without an access");

   chk_other_dword_zero: assert property (
      cfg_req_i.rd && !dw_hit(cfg_req_i.addr) |=> cfg_rdata_o == '0)
      else $error("unmapped dword read as nonzero");

   chk_cmd_b2b_zero: assert property (
      seq_cfg_read |=> cfg_ack_o && !cfg_rdata_o[CMD_FAST_B2B_BIT])
      else $error("fast back-to-back enable read as 1");

   chk_enable_gates_msg: assert property (
      !system_error_msg_enable_r |=> !serr_msg_o)
      else $error("message sent while enable is 0");

   chk_enable_write: assert property (
      lane_wr(cfg_req_i, CMD_SERR_EN_BIT) |=> system_error_msg_enable_r ==
         $past(cfg_req_i.wdata[CMD_SERR_EN_BIT]))
      else $error("enable bit did not take the written value");

   chk_enable_holds: assert property (
      !lane_wr(cfg_req_i, CMD_SERR_EN_BIT) |=>
         $stable(system_error_msg_enable_r))
      else $error("enable bit changed without a write");

   chk_serr_msg_sent: assert property (
      system_error_msg_enable_r && err_hit |=> serr_msg_o)
      else $error("enabled error condition sent no message");

   chk_serr_or_mech: assert property (
      ##1 serr_mech_en_o ==
         $past(system_error_msg_enable_r | other_func_serr_en_i))
      else $error("message path enable not OR of function enables");

   chk_cmd_zero_bits: assert property (
      seq_cfg_read |=> cfg_rdata_o[7:5] == 3'h0 && !cfg_rdata_o[3] &&
         !cfg_rdata_o[0])
      else $error("hardwired zero command bit read as 1");

   chk_mwi_never: assert property (
      seq_cfg_read |=> !cfg_rdata_o[CMD_MWI_BIT] && !write_invalidate_o)
      else $error("write-and-invalidate shown enabled");

   chk_bus_master_one: assert property (
      seq_cfg_read |=> cfg_rdata_o[CMD_BUS_MASTER_BIT] && bus_master_en_o)
      else $error("bus master enable read as 0");

   chk_mem_space_one: assert property (
      seq_cfg_read |=> cfg_rdata_o[CMD_MEM_SPACE_BIT] && mem_space_en_o)
      else $error("memory space enable read as 0");

   chk_sys_err_sets: assert property (
      serr_msg_o |=> signalled_system_error)
      else $error("sent message did not set the status flag");

   chk_sys_err_quiet: assert property (
      !serr_msg_o && !signalled_system_error |=> !signalled_system_error)
      else $error("status flag set without a message");

   chk_sys_err_read: assert property (
      signalled_system_error ##0 seq_cfg_read
         |=> cfg_rdata_o[STS_SHIFT + STS_SYS_ERR_BIT])
      else $error("set status flag read as 0");

   chk_sys_err_w1c: assert property (
      seq_sys_err_w1c ##0 !serr_msg_o |=> !signalled_system_error)
      else $error("writing 1 did not clear the status flag");

   chk_sys_err_w0_keeps: assert property (
      seq_sys_err_w0 ##0 signalled_system_error |=> signalled_system_error)
      else $error("writing 0 cleared the status flag");

   chk_sts_ro_bits: assert property (
      cfg_req_i.wr && dw_hit(cfg_req_i.addr) |=>
         !$fell(received_master_abort) && !$fell(received_target_abort))
      else $error("read-only status flag changed by a write");

   chk_master_abort_sets: assert property (
      hub_evt_i.ma_cpl || hub_evt_i.ma_cycle |=> received_master_abort)
      else $error("master abort not recorded");

   chk_master_abort_quiet: assert property (
      !hub_evt_i.ma_cpl && !hub_evt_i.ma_cycle && !received_master_abort
         |=> !received_master_abort)
      else $error("master abort flag set without an abort");

   chk_master_abort_read: assert property (
      received_master_abort ##0 seq_cfg_read
         |=> cfg_rdata_o[STS_SHIFT + STS_MASTER_ABORT_BIT])
      else $error("master abort flag read as 0");

   chk_target_abort_sets: assert property (
      hub_evt_i.ta_cpl || hub_evt_i.ta_cycle |=> received_target_abort)
      else $error("target abort not recorded");

   chk_target_abort_quiet: assert property (
      !hub_evt_i.ta_cpl && !hub_evt_i.ta_cycle && !received_target_abort
         |=> !received_target_abort)
      else $error("target abort flag set without an abort");

   chk_sig_abort_zero: assert property (
      seq_cfg_read |=> !cfg_rdata_o[STS_SHIFT + STS_SIG_ABORT_BIT])
      else $error("signalled target abort read as 1");

   chk_select_fast: assert property (
      seq_cfg_read |=> cfg_rdata_o[STS_SHIFT+10:STS_SHIFT+9] == 2'h0)
      else $error("select timing not fast decode");

   chk_parity_zero: assert property (
      seq_cfg_read |=> !cfg_rdata_o[STS_SHIFT + STS_PARITY_ERR_BIT] &&
         !cfg_rdata_o[STS_SHIFT + STS_DATA_PARITY_BIT])
      else $error("parity error bit read as 1");

   chk_b2b_cap: assert property (
      seq_cfg_read |=> cfg_rdata_o[STS_SHIFT + STS_FAST_B2B_BIT])
      else $error("fast back-to-back capable read as 0");

   chk_cap_list_one: assert property (
      seq_cfg_read |=> cfg_rdata_o[STS_SHIFT + STS_CAP_LIST_BIT])
      else $error("capability list bit read as 0");

   chk_rdata_idle: assert property (
      !rd_hit_r |-> cfg_rdata_o == '0)
      else $error("read data not zero outside a read");

   chk_reserved_zero: assert property (
      seq_cfg_read |=> cfg_rdata_o[15:10] == 6'h00 &&
         cfg_rdata_o[STS_SHIFT+6:STS_SHIFT+5] == 2'h0 &&
         cfg_rdata_o[STS_SHIFT+3:STS_SHIFT] == 4'h0)
      else $error("reserved bit read as 1");

endmodule : host_bridge_cmd_status

// file: shared/host_bridge_cfg_pkg.sv
package host_bridge_cfg_pkg;

   // configuration offsets (bytes); command and status share one dword
   localparam logic [7:0] CMD_OFFSET = 8'h04;
   localparam logic [7:0] STS_OFFSET = 8'h06;
   localparam logic [7:0] CAP_PTR_OFFSET = 8'h34;
   localparam int DW_LSB = 2;
   localparam int STS_SHIFT = 16;

   localparam logic [15:0] CMD_RESET = 16'h0006;
   localparam logic [15:0] STS_RESET = 16'h0090;
   // bits that read as constant 1; every other unlisted bit reads 0
   localparam logic [15:0] CMD_ONES = 16'h0006;
   localparam logic [15:0] STS_ONES = 16'h0090;

   localparam int CMD_FAST_B2B_BIT = 9;
   localparam int CMD_SERR_EN_BIT = 8;
   localparam int CMD_MWI_BIT = 4;
   localparam int CMD_BUS_MASTER_BIT = 2;
   localparam int CMD_MEM_SPACE_BIT = 1;
   localparam int STS_PARITY_ERR_BIT = 15;
   localparam int STS_SYS_ERR_BIT = 14;
   localparam int STS_MASTER_ABORT_BIT = 13;
   localparam int STS_TARGET_ABORT_BIT = 12;
   localparam int STS_SIG_ABORT_BIT = 11;
   localparam int STS_DATA_PARITY_BIT = 8;
   localparam int STS_FAST_B2B_BIT = 7;
   localparam int STS_CAP_LIST_BIT = 4;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } cfg_req_t;

   typedef struct packed {
      logic ma_cpl;
      logic ma_cycle;
      logic ta_cpl;
      logic ta_cycle;
   } hub_evt_t;

endpackage : host_bridge_cfg_pkg

// file: logic/sticky_flag.sv
`timescale 1ns/1ps
module sticky_flag (
   input wire logic core_clk_i, // core clock
   input wire logic rst_i,      // sync reset, high
   input wire logic set_i,      // event pulse
   input wire logic clr_i,      // clear request
   output logic q_o             // flag level
);
   logic q_r;

   // set beats clear so an event in the clearing cycle survives
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         q_r <= 1'b0;
      end else if (set_i) begin
         q_r <= 1'b1;
      end else if (clr_i) begin
         q_r <= 1'b0;
      end
   end

   assign q_o = q_r;
endmodule : sticky_flag

// file: dv/host_bridge_cmd_status_tb_top.sv
`timescale 1ns/1ps
module host_bridge_cmd_status_tb_top;
   import host_bridge_cfg_pkg::*;
   localparam int W = 8;
   localparam int LIMIT = 3000;
   logic core_clk_i;
   logic rst_i;
   logic ack;
   logic serr_msg;
   logic mech_en;
   logic mst;
   logic mse;
   logic mwi;
   logic other_en;
   logic [31:0] rdata;
   logic [W-1:0] cond;
   logic [W-1:0] cond_en;
   cfg_req_t req;
   hub_evt_t evt;
   int n_mismatch = 0;
   int compares = 0;
   int cycles = 0;

   host_bridge_cmd_status #(.ERR_COND_W(W)) dut_u (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .cfg_req_i(req),
      .cfg_ack_o(ack),
      .cfg_rdata_o(rdata),
      .err_cond_i(cond),
      .err_cmd_en_i(cond_en),
      .other_func_serr_en_i(other_en),
      .hub_evt_i(evt),
      .serr_msg_o(serr_msg),
      .serr_mech_en_o(mech_en),
      .bus_master_en_o(mst),
      .mem_space_en_o(mse),
      .write_invalidate_o(mwi)
   );

   initial begin
      core_clk_i = 1'b0;
      forever #25 core_clk_i = ~core_clk_i;
   end

   task automatic conclude();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : conclude

   // a hang is cut short well past the expected run length
   always @(posedge core_clk_i) begin
      cycles = cycles + 1;
      if (cycles > LIMIT) begin
         n_mismatch = n_mismatch + 1;
         conclude();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares = compares + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic do_reset();
      rst_i = 1'b1;
      repeat (3) @(negedge core_clk_i);
      rst_i = 1'b0;
   endtask : do_reset

   // one config cycle; read data is only compared for reads
   task automatic access(input logic w, input logic [7:0] a,
                         input logic [3:0] be, input logic [31:0] d,
                         input logic [31:0] exp);
      @(negedge core_clk_i);
      req.rd = ~w;
      req.wr = w;
      req.addr = a;
      req.be = be;
      req.wdata = d;
      @(negedge core_clk_i);
      check({31'h0, ack}, 32'h0000_0001);
      if (!w) begin
         check(rdata, exp);
      end
      req = '0;
   endtask : access

   task automatic pulse_cond(input logic [W-1:0] c, input logic exp);
      cond = c;
      @(negedge core_clk_i);
      cond = '0;
      check({31'h0, serr_msg}, {31'h0, exp});
      @(negedge core_clk_i);
      check({31'h0, serr_msg}, 32'h0);
   endtask : pulse_cond

   initial begin
      rst_i = 1'b1;
      req = '0;
      cond = '0;
      cond_en = '0;
      other_en = 1'b0;
      evt = '0;
      do_reset();
      check({29'h0, mst, mse, mwi}, 32'h0000_0006);
      access(1'b0, 8'h04, 4'h0, 32'h0, 32'h0090_0006);
      access(1'b1, 8'h04, 4'hf, 32'hffff_ffff, 32'h0);
      access(1'b0, 8'h04, 4'h0, 32'h0, 32'h0090_0106);
      check({31'h0, mech_en}, 32'h0000_0001);
      // condition high but its own enable low: no message
      cond_en = 8'h02;
      pulse_cond(8'h01, 1'b0);
      access(1'b0, 8'h04, 4'h0, 32'h0, 32'h0090_0106);
      cond_en = 8'h01;
      pulse_cond(8'h01, 1'b1);
      access(1'b0, 8'h04, 4'h0, 32'h0, 32'h4090_0106);
      // lane 3 disabled, then zero written: flag must stay
      access(1'b1, 8'h04, 4'h7, 32'hffff_ffff, 32'h0);
      access(1'b1, 8'h04, 4'h8, 32'h0, 32'h0);
      access(1'b0, 8'h04, 4'h0, 32'h0, 32'h4090_0106);
      access(1'b1, 8'h04, 4'h8, 32'h4000_0000, 32'h0);
      access(1'b0, 8'h04, 4'h0, 32'h0, 32'h0090_0106);
      access(1'b1, 8'h04, 4'h2, 32'h0, 32'h0);
      access(1'b0, 8'h04, 4'h0, 32'h0, 32'h0090_0006);
      check({31'h0, mech_en}, 32'h0);
      other_en = 1'b1;
      @(negedge core_clk_i);
      check({31'h0, mech_en}, 32'h0000_0001);
      other_en = 1'b0;
      pulse_cond(8'h01, 1'b0);
      access(1'b0, 8'h04, 4'h0, 32'h0, 32'h0090_0006);
      access(1'b0, 8'h08, 4'h0, 32'h0, 32'h0);
      // each abort source alone, flags survive an all-ones write
      for (int i = 0; i < 4; i++) begin
         do_reset();
         evt = hub_evt_t'(4'h1 << i);
         @(negedge core_clk_i);
         evt = '0;
         access(1'b1, 8'h04, 4'hf, 32'hffff_ffff, 32'h0);
         access(1'b0, 8'h04, 4'h0, 32'h0, (i >= 2) ? 32'h2090_0106 :
                32'h1090_0106);
      end
      conclude();
   end
endmodule : host_bridge_cmd_status_tb_top
